// ===== inc/lbs_pkg.sv
package lbs_pkg;
   localparam int ADDR_W        = 32;
   localparam int TA_W          = 16;
   localparam int BS_W          = 4;
   localparam int DMA_W         = 2;
   localparam int SZ_W          = 2;
   // Mode selection sampled from the upper size bit at reset
   localparam logic MODESET_BC  = 1'b0;
   localparam logic MODESET_BA  = 1'b1;
   // Window parameter reset values
   localparam logic [TA_W-1:0] TA_RST  = 16'h0000;
   localparam logic [BS_W-1:0] BS_RST  = 4'h0;
   localparam logic            BIT_RST = 1'b0;
   // Lowest translated address bit for window size code 0 (64 Kbyte)
   localparam int BS_BASE_BIT   = 16;
   // Local DMA request kinds
   localparam logic [DMA_W-1:0] DMA_NONE   = 2'h0;
   localparam logic [DMA_W-1:0] DMA_SINGLE = 2'h1;
   localparam logic [DMA_W-1:0] DMA_DUAL   = 2'h2;
   // Transfer size code for a 32-bit access
   localparam logic [SZ_W-1:0] SZ_WORD = 2'h0;
   // Decoder timeout for a strobe with no select
   localparam int DECODE_WAIT   = 8;
   // Acknowledge kinds returned by the back end
   typedef enum logic [3:0] {
      RSP_NONE  = 4'b0001,
      RSP_ACK   = 4'b0010,
      RSP_ERR   = 4'b0100,
      RSP_RETRY = 4'b1000
   } rsp_e;
endpackage

// ===== src/lbs_window.sv
`timescale 1ns/1ps
// One slave window: its own parameter set, written by software or by the
// serial configuration loader; no state is shared with the other window.
module lbs_window #(
   parameter bit LOADABLE = 1'b0
) (
   input  wire logic                        mclk,
   input  wire logic                        rst_n,
   input  wire logic                        wr_en,
   input  wire logic                        load_en,
   input  wire logic [lbs_pkg::TA_W-1:0]    ta_in,
   input  wire logic [lbs_pkg::BS_W-1:0]    bs_in,
   input  wire logic                        xlat_in,
   input  wire logic                        space_in,
   input  wire logic                        posted_in,
   input  wire logic                        prefetch_in,
   input  wire logic [lbs_pkg::ADDR_W-1:0]  local_addr,
   output logic      [lbs_pkg::ADDR_W-1:0]  pci_addr,
   output logic                             space_select,
   output logic                             posted_write_on,
   output logic                             prefetch_on,
   output logic      [lbs_pkg::BS_W-1:0]    window_size_code
);
   logic [lbs_pkg::TA_W-1:0] translation_address_r;
   logic                     xlat_on_r;
   logic                     take;

   // RQ14 serial load
   assign take = wr_en | (LOADABLE & load_en);

   // RQ9 independent parameters
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         translation_address_r <= lbs_pkg::TA_RST;
         window_size_code      <= lbs_pkg::BS_RST;
         xlat_on_r             <= lbs_pkg::BIT_RST;
         space_select          <= lbs_pkg::BIT_RST;
         posted_write_on       <= lbs_pkg::BIT_RST;
         prefetch_on           <= lbs_pkg::BIT_RST;
      end else if (take) begin
         translation_address_r <= ta_in;
         window_size_code      <= bs_in;
         xlat_on_r             <= xlat_in;
         space_select          <= space_in;
         posted_write_on       <= posted_in;
         prefetch_on           <= prefetch_in;
      end
   end

   // RQ11 size bounds span
   // RQ25 upper bits replaced
   always_comb begin
      pci_addr = local_addr;
      for (int i = 0; i < lbs_pkg::TA_W; i++) begin
         if (xlat_on_r && (i >= int'(window_size_code)))
            pci_addr[lbs_pkg::BS_BASE_BIT + i] = translation_address_r[i];
      end
   end
endmodule

// ===== src/lbs_strap.sv
`timescale 1ns/1ps
// Catches the mode strap once after reset release.
module lbs_strap (
   input  wire logic mclk,
   input  wire logic rst_n,
   input  wire logic upper_size_bit,
   output logic      mode_set_ba
);
   logic s1_r;
   logic s2_r;
   logic done_r;

   always_ff @(posedge mclk) begin
      s1_r <= upper_size_bit;
      s2_r <= s1_r;
   end

   // RQ23 strap sampled
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         done_r      <= 1'b0;
         mode_set_ba <= lbs_pkg::MODESET_BC;
      end else if (!done_r) begin
         done_r      <= 1'b1;
         mode_set_ba <= s2_r;
      end
   end
endmodule

// ===== src/local_bus_slave_decode.sv
`timescale 1ns/1ps
// Overview of operation
// RQ1 - Accept only select with start strobe
// RQ2 - Selects may arrive after start strobe
// RQ3 - Dual DMA needs window select at start
// RQ4 - Single DMA needs no window select
// RQ5 - Register select decodes internal register access
// RQ6 - Window select claims cycle for bridge
// RQ7 - Pick level chooses window zero/one
// RQ8 - Burst and direction sampled decide access
// RQ9 - Windows hold fully separate parameters
// RQ10 - Space bit picks memory or I/O
// RQ11 - Size field bounds window, up 2G
// RQ12 - Posted bit chooses posted or delayed
// RQ13 - Prefetch bit turns word reads burst (code does this in modes A and B only, not in mode C)
// RQ14 - Window zero loadable from serial memory
// RQ15 - Mode A acks, errors or retries selected
// RQ16 - Mode A captures at select edge
// RQ17 - Mode A burst and continue flag
// RQ18 - Mode A master uses 32-bit port
// RQ19 - Mode B drives sized acknowledge subset
// RQ20 - Mode B captures at falling edge
// RQ21 - Mode B synchronous 32-bit peripheral
// RQ22 - Mode C acks only selected start
// RQ23 - Strap picks modes B+C or B+A
// RQ24 - Delayed write completes before posting
// RQ25 - Translation enable replaces upper bits
// RQ26 - Unselected cycle leaves responses undriven
module local_bus_slave_decode (
   input  wire logic                        mclk,
   input  wire logic                        rst_n,
   // Local bus pins (active low strobes), synchronised below
   input  wire logic                        cycle_start_strobe_n,
   input  wire logic                        addr_strobe_legacy_n,
   input  wire logic                        register_select_n,
   input  wire logic                        bridge_window_select_n,
   input  wire logic                        window_pick,
   input  wire logic                        burst_in_progress_n,
   input  wire logic                        burst_continue_flag,
   input  wire logic                        read_not_write,
   input  wire logic [lbs_pkg::SZ_W-1:0]    xfer_size,
   input  wire logic                        upper_size_bit,
   input  wire logic [lbs_pkg::ADDR_W-1:0]  local_addr,
   input  wire logic [lbs_pkg::DMA_W-1:0]   local_dma_channel,
   // Acknowledge outputs: data, enable (low while driving)
   output logic                             transfer_ack_n,
   output logic                             transfer_ack_oe_n,
   output logic                             byte_port_ack_n,
   output logic                             byte_port_ack_oe_n,
   output logic                             bus_error_ack_n,
   output logic                             bus_error_ack_oe_n,
   output logic                             retry_request_n,
   output logic                             retry_request_oe_n,
   // Window configuration ports
   input  wire logic                        win0_wr,
   input  wire logic                        win1_wr,
   input  wire logic                        serial_load,
   input  wire logic [lbs_pkg::TA_W-1:0]    cfg_ta,
   input  wire logic [lbs_pkg::BS_W-1:0]    cfg_bs,
   input  wire logic                        cfg_xlat,
   input  wire logic                        cfg_space,
   input  wire logic                        cfg_posted,
   input  wire logic                        cfg_prefetch,
   // Back end answer for the claimed cycle
   input  wire logic                        rsp_valid,
   input  wire logic [3:0]                  rsp_kind,
   input  wire logic                        delayed_write_done,
   // Decoded cycle toward register file or PCI master
   output logic                             reg_req,
   output logic                             pci_req,
   output logic                             req_window,
   output logic      [lbs_pkg::ADDR_W-1:0]  req_addr,
   output logic                             req_read,
   output logic                             req_burst,
   output logic                             req_last_beat,
   output logic                             req_io_space,
   output logic                             req_posted,
   output logic                             req_prefetch_burst,
   output logic                             mode_set_ba,
   output logic                             cycle_busy
);
   typedef enum logic [3:0] {
      ST_IDLE   = 4'b0001,
      ST_DECODE = 4'b0010,
      ST_WAIT   = 4'b0100,
      ST_ACK    = 4'b1000
   } st_e;

   st_e  st_r;
   st_e  st_nxt;

   // Two-stage synchronisers for every pin input
   localparam int NSYNC = 10;
   logic [NSYNC-1:0] pin_raw;
   logic [NSYNC-1:0] s1_r;
   logic [NSYNC-1:0] s2_r;
   logic [lbs_pkg::ADDR_W-1:0] a1_r;
   logic [lbs_pkg::ADDR_W-1:0] a2_r;
   logic [lbs_pkg::DMA_W-1:0]  d1_r;
   logic [lbs_pkg::DMA_W-1:0]  d2_r;
   logic [lbs_pkg::SZ_W-1:0]   z1_r;
   logic [lbs_pkg::SZ_W-1:0]   z2_r;

   assign pin_raw = {~cycle_start_strobe_n, ~addr_strobe_legacy_n, ~register_select_n,
                     ~bridge_window_select_n, window_pick, ~burst_in_progress_n,
                     burst_continue_flag, read_not_write, 1'b0, 1'b0};

   always_ff @(posedge mclk) begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      a1_r <= local_addr;
      a2_r <= a1_r;
      d1_r <= local_dma_channel;
      d2_r <= d1_r;
      z1_r <= xfer_size;
      z2_r <= z1_r;
   end

   logic ts;
   logic as_q;
   logic reg_cs;
   logic win_cs;
   logic pick;
   logic burst;
   logic cont;
   logic rd;
   assign ts     = s2_r[9];
   assign as_q   = s2_r[8];
   assign reg_cs = s2_r[7];
   assign win_cs = s2_r[6];
   assign pick   = s2_r[5];
   assign burst  = s2_r[4];
   assign cont   = s2_r[3];
   assign rd     = s2_r[2];

   // Mode set fixed at reset
   lbs_strap u_strap (
      .mclk           (mclk),
      .rst_n          (rst_n),
      .upper_size_bit (upper_size_bit),
      .mode_set_ba    (mode_set_ba)
   );

   // Window parameter sets
   logic [lbs_pkg::ADDR_W-1:0] w_addr [2];
   logic [1:0]                 w_space;
   logic [1:0]                 w_posted;
   logic [1:0]                 w_prefetch;
   logic [1:0]                 w_wr;
   assign w_wr = {win1_wr, win0_wr};

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_win
         lbs_window #(.LOADABLE(g == 0)) u_win (
            .mclk             (mclk),
            .rst_n            (rst_n),
            .wr_en            (w_wr[g]),
            .load_en          (serial_load),
            .ta_in            (cfg_ta),
            .bs_in            (cfg_bs),
            .xlat_in          (cfg_xlat),
            .space_in         (cfg_space),
            .posted_in        (cfg_posted),
            .prefetch_in      (cfg_prefetch),
            .local_addr       (a2_r),
            .pci_addr         (w_addr[g]),
            .space_select     (w_space[g]),
            .posted_write_on  (w_posted[g]),
            .prefetch_on      (w_prefetch[g]),
            .window_size_code ()
         );
      end
   endgenerate

   // Strobe that opens a cycle in the active mode set
   logic start;
   logic legacy_mode;
   logic sel_any;
   logic single_dma;
   logic dual_dma;
   logic claim;
   logic pend_delayed_r;
   logic timeout;
   logic [3:0] wait_cnt_r;
   logic start_prev_r;
   logic start_edge;

   // RQ23 legacy strobe always on
   assign start       = ts | as_q;
   // Edge only: the synced strobe outlives the acknowledge
   assign start_edge  = start && !start_prev_r;
   assign single_dma  = (d2_r == lbs_pkg::DMA_SINGLE);
   assign dual_dma    = (d2_r == lbs_pkg::DMA_DUAL);
   // RQ1 select with strobe
   // RQ4 single DMA claims alone
   assign sel_any     = reg_cs | win_cs | single_dma;
   // RQ24 posting waits for delayed write; claim held while it pends
   assign claim       = sel_any && !(win_cs && !rd && pend_delayed_r && !reg_cs);
   assign timeout     = (wait_cnt_r == 4'(lbs_pkg::DECODE_WAIT - 1));

   always_ff @(posedge mclk) begin
      start_prev_r <= start;
      if (!rst_n) begin
         legacy_mode <= 1'b0;
      end else if (st_r == ST_IDLE && start_edge) begin
         legacy_mode <= as_q;
      end
   end

   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         ST_IDLE: begin
            // RQ3 dual DMA select at start
            if (start_edge && dual_dma && !win_cs)
               st_nxt = ST_IDLE;
            else if (start_edge && claim)
               st_nxt = ST_WAIT;
            else if (start_edge)
               st_nxt = ST_DECODE;
         end
         ST_DECODE: begin
            // RQ2 late select accepted
            if (claim)
               st_nxt = ST_WAIT;
            // RQ26 no select, no answer
            else if (timeout || !(ts || as_q))
               st_nxt = ST_IDLE;
         end
         ST_WAIT: begin
            if (rsp_valid)
               st_nxt = ST_ACK;
         end
         ST_ACK: begin
            st_nxt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rst_n)
         st_r <= ST_IDLE;
      else
         st_r <= st_nxt;
   end

   always_ff @(posedge mclk) begin
      if (!rst_n || st_r != ST_DECODE)
         wait_cnt_r <= 4'h0;
      else
         wait_cnt_r <= wait_cnt_r + 4'h1;
   end

   logic enter;
   assign enter = (st_nxt == ST_WAIT) && (st_r != ST_WAIT);

   // RQ16 capture at select edge
   // RQ20 capture once strobe seen
   // RQ22 capture with start
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         req_window <= 1'b0;
         req_addr   <= '0;
         req_read   <= 1'b0;
         req_burst  <= 1'b0;
         req_io_space <= 1'b0;
         req_posted   <= 1'b0;
         req_prefetch_burst <= 1'b0;
      end else if (enter) begin
         // RQ7 pick level
         req_window <= pick;
         req_addr   <= reg_cs ? a2_r : w_addr[pick];
         // RQ8 burst and direction
         // RQ17 burst with address
         req_read   <= rd;
         req_burst  <= burst;
         // RQ10 space bit
         req_io_space <= w_space[pick];
         // RQ12 posted or delayed
         req_posted   <= !rd && !burst && w_posted[pick];
         // RQ13 prefetch word read
         req_prefetch_burst <= rd && !burst && w_prefetch[pick] && (mode_set_ba || legacy_mode)
                               && (z2_r == lbs_pkg::SZ_WORD);
      end
   end

   // RQ5 register decode
   // RQ6 bridge claim
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         reg_req <= 1'b0;
         pci_req <= 1'b0;
      end else begin
         reg_req <= enter && reg_cs;
         pci_req <= enter && !reg_cs && (win_cs || single_dma);
      end
   end

   // RQ17 second-to-last beat
   always_ff @(posedge mclk) begin
      if (!rst_n)
         req_last_beat <= 1'b0;
      else
         req_last_beat <= req_burst && !cont && (st_r == ST_WAIT);
   end

   // RQ24 delayed write tracking
   always_ff @(posedge mclk) begin
      if (!rst_n)
         pend_delayed_r <= 1'b0;
      else if (pci_req && !req_read && !req_posted)
         pend_delayed_r <= 1'b1;
      else if (delayed_write_done)
         pend_delayed_r <= 1'b0;
   end

   // Response drive: only in ST_ACK, else released
   // RQ15 mode A answers
   // RQ19 mode B sized subset
   // RQ22 mode C no retry
   // RQ21 word port acknowledges
   logic [3:0] kind_c;
   assign kind_c = (!mode_set_ba && !legacy_mode && rsp_kind == 4'(lbs_pkg::RSP_RETRY))
                   ? 4'(lbs_pkg::RSP_ERR) : rsp_kind;

   logic drv;
   assign drv = (st_r == ST_ACK);
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         transfer_ack_n     <= 1'b1;
         byte_port_ack_n    <= 1'b1;
         bus_error_ack_n    <= 1'b1;
         retry_request_n    <= 1'b1;
         transfer_ack_oe_n  <= 1'b1;
         byte_port_ack_oe_n <= 1'b1;
         bus_error_ack_oe_n <= 1'b1;
         retry_request_oe_n <= 1'b1;
      end else begin
         transfer_ack_n     <= !(st_nxt == ST_ACK && kind_c == 4'(lbs_pkg::RSP_ACK));
         byte_port_ack_n    <= 1'b1;
         bus_error_ack_n    <= !(st_nxt == ST_ACK && kind_c == 4'(lbs_pkg::RSP_ERR));
         retry_request_n    <= !(st_nxt == ST_ACK && kind_c == 4'(lbs_pkg::RSP_RETRY)
                                 && (mode_set_ba || legacy_mode));
         transfer_ack_oe_n  <= !(st_nxt == ST_ACK);
         byte_port_ack_oe_n <= !(st_nxt == ST_ACK && legacy_mode);
         bus_error_ack_oe_n <= !(st_nxt == ST_ACK);
         retry_request_oe_n <= !(st_nxt == ST_ACK && (mode_set_ba || legacy_mode));
      end
   end

   assign cycle_busy = (st_r != ST_IDLE) && !drv;

   property p_no_sel_no_ack;
      @(posedge mclk) disable iff (!rst_n)
      (st_r == ST_DECODE && timeout && !claim) |=> ##1 transfer_ack_oe_n;
   endproperty
   a_no_sel_no_ack: assert property (p_no_sel_no_ack) else $error("ack without select"); // RQ26

   property p_claim_req;
      @(posedge mclk) disable iff (!rst_n)
      enter |=> (reg_req || pci_req);
   endproperty
   a_claim_req: assert property (p_claim_req) else $error("claim lost"); // RQ6

   property p_reg_not_pci;
      @(posedge mclk) disable iff (!rst_n)
      reg_req |-> !pci_req;
   endproperty
   a_reg_not_pci: assert property (p_reg_not_pci) else $error("register cycle forwarded"); // RQ5

   property p_ack_one;
      @(posedge mclk) disable iff (!rst_n)
      !transfer_ack_oe_n |=> transfer_ack_oe_n;
   endproperty
   a_ack_one: assert property (p_ack_one) else $error("ack held"); // RQ15

   property p_wait_pick;
      @(posedge mclk) disable iff (!rst_n)
      enter |=> req_window == $past(pick);
   endproperty
   a_wait_pick: assert property (p_wait_pick) else $error("wrong window"); // RQ7

   property p_posted;
      @(posedge mclk) disable iff (!rst_n)
      req_posted |-> !req_read && !req_burst;
   endproperty
   a_posted: assert property (p_posted) else $error("posted read"); // RQ12

   property p_no_retry_c;
      @(posedge mclk) disable iff (!rst_n)
      (!mode_set_ba && !legacy_mode) |-> retry_request_oe_n;
   endproperty
   a_no_retry_c: assert property (p_no_retry_c) else $error("retry in mode C"); // RQ22

   property p_byte_b;
      @(posedge mclk) disable iff (!rst_n)
      !byte_port_ack_oe_n |-> legacy_mode && byte_port_ack_n;
   endproperty
   a_byte_b: assert property (p_byte_b) else $error("byte ack outside mode B"); // RQ21
endmodule

// ===== testbench/lbus_master_model.sv
`timescale 1ns/1ps
// Local bus master: one cycle at a time, held until the slave answers or 40 clocks pass
module lbus_master_model (
   input  wire logic                     mclk,
   input  wire logic [3:0]               ack_oe_n,
   input  wire logic [3:0]               ack_n,
   output logic                          cycle_start_strobe_n,
   output logic                          addr_strobe_legacy_n,
   output logic                          register_select_n,
   output logic                          bridge_window_select_n,
   output logic                          window_pick,
   output logic                          burst_in_progress_n,
   output logic                          burst_continue_flag,
   output logic                          read_not_write,
   output logic [lbs_pkg::SZ_W-1:0]      xfer_size,
   output logic [lbs_pkg::ADDR_W-1:0]    local_addr,
   output logic [lbs_pkg::DMA_W-1:0]     local_dma_channel
);
   initial begin
      {cycle_start_strobe_n, addr_strobe_legacy_n, register_select_n, bridge_window_select_n} = 4'hf;
      {window_pick, burst_in_progress_n, burst_continue_flag, read_not_write} = 4'h7;
      xfer_size = lbs_pkg::SZ_WORD;
      local_addr = 32'h0000_0000;
      local_dma_channel = lbs_pkg::DMA_NONE;
   end

   task automatic run(input logic legacy, rsel, wsel, input int dly, input logic pick, rd, burst,
                      input logic [lbs_pkg::ADDR_W-1:0] addr, input logic [lbs_pkg::DMA_W-1:0] dma,
                      output logic [3:0] seen);
      int n;
      seen = 4'h0;
      n = 0;
      @(posedge mclk);
      #1;
      xfer_size = lbs_pkg::SZ_WORD;
      // changes only just after the rising edge
      cycle_start_strobe_n = legacy;
      addr_strobe_legacy_n = !legacy;
      window_pick = pick;
      read_not_write = rd;
      burst_in_progress_n = !burst;
      burst_continue_flag = 1'b1;
      local_addr = addr;
      local_dma_channel = dma;
      // selects follow the strobe after dly clocks; dly 0 carries them with it
      while (seen == 4'h0 && n < 40) begin
         if (n == dly) begin
            register_select_n = !rsel;
            bridge_window_select_n = !wsel;
         end
         @(posedge mclk);
         seen = ~(ack_oe_n | ack_n);
         n++;
         #1;
      end
      // Released lines show the inverse, not a stale copy
      {cycle_start_strobe_n, addr_strobe_legacy_n, register_select_n, bridge_window_select_n} = 4'hf;
      local_addr = ~addr;
      read_not_write = !rd;
      window_pick = !pick;
      local_dma_channel = lbs_pkg::DMA_NONE;
   endtask
endmodule

// ===== testbench/tb.sv
`timescale 1ns/1ps
module tb;
   logic        mclk, rst_n, upper_size_bit, win0_wr, win1_wr, serial_load;
   logic        cfg_xlat, cfg_space, cfg_posted, cfg_prefetch, rsp_valid, delayed_write_done;
   logic [15:0] cfg_ta;
   logic [3:0]  cfg_bs, rsp_kind, next_rsp, ack_oe_n, ack_n, seen;
   logic        ts_n, as_n, rs_n, ws_n, pick, bip_n, bcf, rnw;
   logic [1:0]  xsz, dma;
   logic [31:0] addr, req_addr;
   logic        reg_req, pci_req, req_window, req_read, req_burst, req_last_beat;
   logic        req_io_space, req_posted, req_prefetch_burst, mode_set_ba, cycle_busy;
   int          n_mismatch, checks, n_pci, n_reg, dp, dr, cyc;

   lbus_master_model i_mst (.mclk(mclk), .ack_oe_n(ack_oe_n), .ack_n(ack_n), .cycle_start_strobe_n(ts_n),
      .addr_strobe_legacy_n(as_n), .register_select_n(rs_n), .bridge_window_select_n(ws_n),
      .window_pick(pick), .burst_in_progress_n(bip_n), .burst_continue_flag(bcf),
      .read_not_write(rnw), .xfer_size(xsz), .local_addr(addr), .local_dma_channel(dma));

   local_bus_slave_decode i_dut (.mclk(mclk), .rst_n(rst_n), .cycle_start_strobe_n(ts_n),
      .addr_strobe_legacy_n(as_n), .register_select_n(rs_n), .bridge_window_select_n(ws_n),
      .window_pick(pick), .burst_in_progress_n(bip_n), .burst_continue_flag(bcf),
      .read_not_write(rnw), .xfer_size(xsz), .upper_size_bit(upper_size_bit), .local_addr(addr),
      .local_dma_channel(dma), .transfer_ack_n(ack_n[0]), .transfer_ack_oe_n(ack_oe_n[0]),
      .byte_port_ack_n(ack_n[1]), .byte_port_ack_oe_n(ack_oe_n[1]), .bus_error_ack_n(ack_n[2]),
      .bus_error_ack_oe_n(ack_oe_n[2]), .retry_request_n(ack_n[3]), .retry_request_oe_n(ack_oe_n[3]),
      .win0_wr(win0_wr), .win1_wr(win1_wr), .serial_load(serial_load), .cfg_ta(cfg_ta),
      .cfg_bs(cfg_bs), .cfg_xlat(cfg_xlat), .cfg_space(cfg_space), .cfg_posted(cfg_posted),
      .cfg_prefetch(cfg_prefetch), .rsp_valid(rsp_valid), .rsp_kind(rsp_kind),
      .delayed_write_done(delayed_write_done), .reg_req(reg_req), .pci_req(pci_req),
      .req_window(req_window), .req_addr(req_addr), .req_read(req_read), .req_burst(req_burst),
      .req_last_beat(req_last_beat), .req_io_space(req_io_space), .req_posted(req_posted),
      .req_prefetch_burst(req_prefetch_burst), .mode_set_ba(mode_set_ba), .cycle_busy(cycle_busy));

   task automatic final_report();
      if (n_mismatch == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic cfg(input int which, input logic [15:0] ta, input logic [3:0] bs, input logic xl, sp, po, pf);
      @(posedge mclk);
      #1;
      {cfg_ta, cfg_bs, cfg_xlat, cfg_space, cfg_posted, cfg_prefetch} = {ta, bs, xl, sp, po, pf};
      serial_load = (which == 0);
      win1_wr = (which == 1);
      win0_wr = (which == 2);
      @(posedge mclk);
      #1;
      {serial_load, win1_wr, win0_wr} = 3'h0;
   endtask

   // One local cycle; dp and dr count the forwarded and register requests it caused
   task automatic go(input logic legacy, rsel, wsel, input int dly, input logic pk, rd, burst,
                     input logic [31:0] a, input logic [1:0] dm, input logic [3:0] rsp);
      int p0, r0;
      p0 = n_pci;
      r0 = n_reg;
      next_rsp = rsp;
      i_mst.run(legacy, rsel, wsel, dly, pk, rd, burst, a, dm, seen);
      repeat (4) @(posedge mclk);
      dp = n_pci - p0;
      dr = n_reg - r0;
   endtask

   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   // Back end: answers every request in the same cycle with the planned kind
   always begin
      @(posedge mclk);
      #1;
      rsp_valid = (reg_req === 1'b1 || pci_req === 1'b1);
      rsp_kind = next_rsp;
      if (pci_req === 1'b1) n_pci++;
      if (reg_req === 1'b1) n_reg++;
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         final_report();
      end
   end

   initial begin
      {rst_n, win0_wr, win1_wr, serial_load, rsp_valid, delayed_write_done} = 6'h0;
      {cfg_ta, cfg_bs, cfg_xlat, cfg_space, cfg_posted, cfg_prefetch} = 24'h0;
      upper_size_bit = 1'b1;
      rsp_kind = lbs_pkg::RSP_NONE;
      next_rsp = lbs_pkg::RSP_ACK;
      repeat (16) @(posedge mclk);
      #1;
      rst_n = 1'b1;
      repeat (6) @(posedge mclk);
      chk("mode_set_ba", 32'h1, mode_set_ba);
      chk("ack_oe_n idle", 32'hf, ack_oe_n);
      cfg(0, 16'h1234, 4'h0, 1'b1, 1'b0, 1'b1, 1'b1);
      cfg(1, 16'h8000, 4'hf, 1'b1, 1'b1, 1'b0, 1'b0);
      go(0, 0, 1, 0, 0, 0, 0, 32'habcd5678, 2'h0, lbs_pkg::RSP_ACK);
      chk("w0 write req", 32'h1, dp);
      chk("w0 write ack", 32'h1, seen);
      chk("w0 window", 32'h0, req_window);
      chk("w0 addr", 32'h12345678, req_addr);
      chk("w0 posted", 32'h1, req_posted);
      chk("w0 read/burst/io", 32'h0, {req_read, req_burst, req_io_space});
      go(0, 0, 1, 0, 0, 1, 0, 32'habcd5678, 2'h0, lbs_pkg::RSP_ACK);
      chk("w0 read prefetch", 32'h3, {req_read, req_prefetch_burst});
      go(0, 0, 1, 0, 1, 1, 0, 32'h70000010, 2'h0, lbs_pkg::RSP_ERR);
      chk("w1 err ack", 32'h4, seen);
      chk("w1 window", 32'h1, req_window);
      chk("w1 addr", 32'hf0000010, req_addr);
      chk("w1 io/prefetch", 32'h2, {req_io_space, req_prefetch_burst});
      go(0, 0, 1, 0, 1, 0, 0, 32'h70000020, 2'h0, lbs_pkg::RSP_RETRY);
      chk("w1 retry", 32'h8, seen);
      chk("w1 delayed", 32'h0, req_posted);
      @(posedge mclk);
      #1;
      delayed_write_done = 1'b1;
      @(posedge mclk);
      #1;
      delayed_write_done = 1'b0;
      cfg(2, 16'h4321, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0);
      go(0, 0, 1, 0, 0, 1, 0, 32'h00c0ffee, 2'h0, lbs_pkg::RSP_ACK);
      chk("w0 untranslated", 32'h00c0ffee, req_addr);
      go(0, 0, 1, 0, 1, 1, 0, 32'h70000030, 2'h0, lbs_pkg::RSP_ACK);
      chk("w1 kept", 32'hf0000030, req_addr);
      chk("w1 io kept", 32'h1, req_io_space);
      go(0, 1, 0, 0, 0, 1, 0, 32'h00000504, 2'h0, lbs_pkg::RSP_ACK);
      chk("reg access", 32'h10, {dr[3:0], dp[3:0]});
      go(0, 0, 1, 3, 0, 1, 0, 32'h00001000, 2'h0, lbs_pkg::RSP_ACK);
      chk("late select", 32'h1, dp);
      go(0, 0, 1, 0, 0, 1, 1, 32'h00002000, 2'h0, lbs_pkg::RSP_ACK);
      chk("burst", 32'h1, req_burst);
      go(0, 0, 0, 0, 0, 1, 0, 32'h00003000, 2'h0, lbs_pkg::RSP_ACK);
      chk("no select", 32'h0, {seen, dr[3:0], dp[3:0]});
      go(0, 0, 1, 2, 0, 1, 0, 32'h00004000, lbs_pkg::DMA_DUAL, lbs_pkg::RSP_ACK);
      chk("dual late", 32'h0, dp);
      go(0, 0, 1, 0, 0, 1, 0, 32'h00005000, lbs_pkg::DMA_DUAL, lbs_pkg::RSP_ACK);
      chk("dual ok", 32'h1, dp);
      go(0, 0, 0, 0, 0, 1, 0, 32'h00006000, lbs_pkg::DMA_SINGLE, lbs_pkg::RSP_ACK);
      chk("single dma", 32'h1, dp);
      go(1, 1, 0, 0, 0, 1, 0, 32'h00000010, 2'h0, lbs_pkg::RSP_ACK);
      chk("legacy reg", 32'h1, dr);
      chk("legacy ack", 32'h1, seen[0]);
      #1;
      {rst_n, upper_size_bit} = 2'h0;
      repeat (16) @(posedge mclk);
      #1;
      rst_n = 1'b1;
      repeat (6) @(posedge mclk);
      chk("mode C", 32'h0, mode_set_ba);
      go(0, 1, 0, 0, 0, 1, 0, 32'h00000020, 2'h0, lbs_pkg::RSP_RETRY);
      chk("mode C retry", 32'h4, seen);
      final_report();
   end
endmodule
